// >>> hdl/ccsc_osc_ready.sv
`timescale 1ns/1ps
`default_nettype none
module ccsc_osc_ready (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic stable_async,
  input  wire logic enable,
  output logic      ready,
  output logic      ready_rise
);

  logic sync1_r;
  logic sync2_r;
  logic ready_nxt;

  // Two-stage synchroniser for the analog stable indication
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= stable_async;
      sync2_r <= sync1_r;
    end
  end

  assign ready_nxt = sync2_r & enable;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ready      <= 1'b0;
      ready_rise <= 1'b0;
    end else begin
      ready      <= ready_nxt;
      ready_rise <= ready_nxt & ~ready;
    end
  end

endmodule : ccsc_osc_ready
`default_nettype wire

// >>> hdl/ccsc_pkg.sv
package ccsc_pkg;

  localparam int CCSC_ADDR_W = 8;
  localparam int CCSC_NOSC   = 6;

  // Register byte offsets
  localparam logic [7:0] CCSC_OFF_CTRL = 8'h00;
  localparam logic [7:0] CCSC_OFF_CAL  = 8'h04;
  localparam logic [7:0] CCSC_OFF_CFG  = 8'h08;
  localparam logic [7:0] CCSC_OFF_INT  = 8'h0c;

  // Oscillator indices, shared by enable, ready, flag and gate vectors
  localparam int CCSC_IX_SLOW_INT = 0;
  localparam int CCSC_IX_SLOW_EXT = 1;
  localparam int CCSC_IX_FAST_RC  = 2;
  localparam int CCSC_IX_MULTI    = 3;
  localparam int CCSC_IX_FAST_EXT = 4;
  localparam int CCSC_IX_PLL      = 5;

  // Control register fields
  localparam int CCSC_CTRL_EN_LSB  = 0;
  localparam int CCSC_CTRL_RDY_LSB = 8;
  localparam int CCSC_CTRL_BYP_BIT = 16;

  // Calibration register fields
  localparam int CCSC_CAL_FRC_CAL_LSB  = 0;
  localparam int CCSC_CAL_FRC_TRIM_LSB = 8;
  localparam int CCSC_CAL_RANGE_LSB    = 13;
  localparam int CCSC_CAL_MS_CAL_LSB   = 16;
  localparam int CCSC_CAL_MS_TRIM_LSB  = 24;

  // Configuration register fields
  localparam int CCSC_CFG_SW_LSB      = 0;
  localparam int CCSC_CFG_SWS_LSB     = 4;
  localparam int CCSC_CFG_PLL_SRC_BIT = 8;
  localparam int CCSC_CFG_PLL_MUL_LSB = 10;
  localparam int CCSC_CFG_PLL_DIV_LSB = 16;

  // Interrupt register fields
  localparam int CCSC_INT_FLAG_LSB = 0;
  localparam int CCSC_INT_IE_LSB   = 8;
  localparam int CCSC_INT_CLR_LSB  = 16;

  // Reset values and the highest accepted range code
  localparam logic [4:0] CCSC_FRC_TRIM_RST = 5'h10;
  localparam logic [2:0] CCSC_RANGE_RST    = 3'h5;
  localparam logic [2:0] CCSC_RANGE_MAX    = 3'h6;
  localparam logic [7:0] CCSC_MS_TRIM_RST  = 8'h00;
  localparam logic [3:0] CCSC_PLL_MUL_RST  = 4'h0;
  localparam logic [1:0] CCSC_PLL_DIV_RST  = 2'h1;
  localparam logic [5:0] CCSC_EN_RST       = 6'h08;

  // Cycles with the system clock gated during a source changeover
  localparam logic [2:0] CCSC_GAP_CYC = 3'h4;

  typedef enum logic [1:0] {
    CCSC_SRC_MULTI    = 2'h0,
    CCSC_SRC_FAST_RC  = 2'h1,
    CCSC_SRC_FAST_EXT = 2'h2,
    CCSC_SRC_PLL      = 2'h3
  } ccsc_src_type;

  typedef enum logic [2:0] {
    CCSC_SW_IDLE = 3'b001,
    CCSC_SW_WAIT = 3'b010,
    CCSC_SW_GAP  = 3'b100
  } ccsc_sw_state_type;

  typedef struct packed {
    logic       src;
    logic [3:0] mul;
    logic [1:0] div;
  } ccsc_pll_cfg_type;

  typedef struct packed {
    logic [5:0] enable;
    logic [5:0] release_gate;
    logic       slow_ext_bypass;
    logic [7:0] fast_rc_factory_cal;
    logic [4:0] fast_rc_trim;
    logic [2:0] multispeed_range;
    logic [7:0] multispeed_factory_cal;
    logic [7:0] multispeed_trim;
  } ccsc_osc_drive_type;

endpackage : ccsc_pkg

// >>> hdl/ccsc_top.sv
// Operation
// - Every reset loads the fast RC factory calibration byte.
// - Fast RC trim is five bits, resets to 16, higher means faster.
// - Fast RC follows its enable; ready once stable; output gated until ready.
// - Multispeed range is three bits, seven frequencies, default 2.097 MHz.
// - Multispeed RC becomes system clock after reset, Stop and Standby wake-up.
// - Standby and reset restore range; Stop keeps calibration and trim.
// - Multispeed RC follows its enable; ready once stable; gated until ready.
// - Reset loads multispeed factory calibration; separate 8-bit trim for software.
// - PLL input selects fast internal RC or fast external oscillator.
// - Kernel clock for USB and card is VCO divided by two.
// - PLL system clock is VCO divided by programmed output divider.
// - PLL source, multiplier and divider change only while PLL disabled.
// - Enabled interrupt fires when the PLL locks.
// - Slow external oscillator: enable, ready, gated until ready, ready interrupt.
// - Bypass plus enable selects external clock up to 1 MHz.
// - Slow internal RC follows enable unless the watchdog forces it on.
// - Slow internal RC: ready when stable, gated until then, ready interrupt.
// - An oscillator feeding the system clock ignores requests to stop.
// - Clock switch completes only once target ready; status shows sources.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ccsc_top
  import ccsc_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [CCSC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [7:0]             fast_rc_factory_cal,
  input  wire logic [7:0]             multispeed_factory_cal,
  input  wire logic [5:0]             osc_stable,
  input  wire logic                   watchdog_active,
  input  wire logic                   stop_wakeup,
  input  wire logic                   standby_wakeup,
  output ccsc_osc_drive_type          osc_drive,
  output ccsc_pll_cfg_type            pll_cfg,
  output ccsc_src_type                system_clock_sel,
  output logic                        system_clock_run,
  output logic                        clk_irq
);

  logic [5:0]        en_r;
  logic              bypass_r;
  logic [7:0]        frc_cal_r;
  logic [4:0]        frc_trim_r;
  logic [2:0]        range_r;
  logic [7:0]        ms_cal_r;
  logic [7:0]        ms_trim_r;
  ccsc_pll_cfg_type  pll_cfg_r;
  ccsc_src_type      sw_r;
  ccsc_src_type      sws_r;
  ccsc_src_type      tgt_r;
  ccsc_sw_state_type state_r;
  logic [2:0]        gap_cnt_r;
  logic [5:0]        flag_r;
  logic [5:0]        ie_r;
  logic [5:0]        ready;
  logic [5:0]        ready_rise;
  logic [5:0]        in_use;
  logic [5:0]        en_eff;
  logic              wd_sync1_r;
  logic              wd_sync2_r;
  logic              wake;
  logic              wr_acc;
  logic              rd_setup;
  logic [31:0]       rd_mux;

  function automatic logic ccsc_mapped(input logic [CCSC_ADDR_W-1:0] a);
    return (a == CCSC_OFF_CTRL) || (a == CCSC_OFF_CAL) || (a == CCSC_OFF_CFG) || (a == CCSC_OFF_INT);
  endfunction : ccsc_mapped

  function automatic logic [2:0] ccsc_src_ix(input ccsc_src_type s);
    case (s)
      CCSC_SRC_FAST_RC:  return 3'(CCSC_IX_FAST_RC);
      CCSC_SRC_FAST_EXT: return 3'(CCSC_IX_FAST_EXT);
      CCSC_SRC_PLL:      return 3'(CCSC_IX_PLL);
      default:           return 3'(CCSC_IX_MULTI);
    endcase
  endfunction : ccsc_src_ix

  // Oscillators that feed the running system clock, directly or via the PLL
  function automatic logic [5:0] ccsc_in_use(input ccsc_src_type s, input logic pll_src);
    logic [5:0] m;
    m = '0;
    m[ccsc_src_ix(s)] = 1'b1;
    if (s == CCSC_SRC_PLL) begin
      if (pll_src) begin
        m[CCSC_IX_FAST_EXT] = 1'b1;
      end else begin
        m[CCSC_IX_FAST_RC] = 1'b1;
      end
    end
    return m;
  endfunction : ccsc_in_use

  // APB slave: zero wait states, error on unmapped offsets
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~ccsc_mapped(paddr);
  assign wr_acc   = psel & penable & pwrite & ccsc_mapped(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wake     = stop_wakeup | standby_wakeup;
  assign in_use   = ccsc_in_use(sws_r, pll_cfg_r.src);

  always_ff @(posedge mclk) begin
    if (rst) begin
      wd_sync1_r <= 1'b0;
      wd_sync2_r <= 1'b0;
    end else begin
      wd_sync1_r <= watchdog_active;
      wd_sync2_r <= wd_sync1_r;
    end
  end

  always_comb begin
    en_eff = en_r;
    en_eff[CCSC_IX_SLOW_INT] = en_r[CCSC_IX_SLOW_INT] | wd_sync2_r;
  end

  // One ready tracker per oscillator and the PLL lock
  for (genvar i = 0; i < CCSC_NOSC; i++) begin : g_rdy
    ccsc_osc_ready u_rdy (
      .mclk         (mclk),
      .rst          (rst),
      .stable_async (osc_stable[i]),
      .enable       (en_eff[i]),
      .ready        (ready[i]),
      .ready_rise   (ready_rise[i])
    );
  end

  // Enables; stop requests on live sources are ignored
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_r     <= CCSC_EN_RST;
      bypass_r <= 1'b0;
    end else if (wake) begin
      en_r[CCSC_IX_MULTI]    <= 1'b1;
      en_r[CCSC_IX_FAST_RC]  <= 1'b0;
      en_r[CCSC_IX_FAST_EXT] <= 1'b0;
      en_r[CCSC_IX_PLL]      <= 1'b0;
    end else if (wr_acc && paddr == CCSC_OFF_CTRL) begin
      en_r <= pwdata[CCSC_CTRL_EN_LSB +: CCSC_NOSC] | in_use;
      if (!en_r[CCSC_IX_SLOW_EXT]) begin
        bypass_r <= pwdata[CCSC_CTRL_BYP_BIT];
      end
    end
  end

  // Calibration and trim; Stop wake-up keeps them, Standby restores trim and range only
  always_ff @(posedge mclk) begin
    if (rst) begin
      frc_cal_r  <= fast_rc_factory_cal;
      ms_cal_r   <= multispeed_factory_cal;
      frc_trim_r <= CCSC_FRC_TRIM_RST;
      range_r    <= CCSC_RANGE_RST;
      ms_trim_r  <= CCSC_MS_TRIM_RST;
    end else if (standby_wakeup) begin
      frc_trim_r <= CCSC_FRC_TRIM_RST;
      range_r    <= CCSC_RANGE_RST;
      ms_trim_r  <= CCSC_MS_TRIM_RST;
    end else if (wr_acc && paddr == CCSC_OFF_CAL) begin
      frc_trim_r <= pwdata[CCSC_CAL_FRC_TRIM_LSB +: 5];
      ms_trim_r  <= pwdata[CCSC_CAL_MS_TRIM_LSB +: 8];
      if (pwdata[CCSC_CAL_RANGE_LSB +: 3] <= CCSC_RANGE_MAX) begin
        range_r <= pwdata[CCSC_CAL_RANGE_LSB +: 3];
      end
    end
  end

  // PLL configuration, frozen while the PLL is enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_cfg_r <= '{src: 1'b0, mul: CCSC_PLL_MUL_RST, div: CCSC_PLL_DIV_RST};
    end else if (wr_acc && paddr == CCSC_OFF_CFG && !en_r[CCSC_IX_PLL]) begin
      pll_cfg_r.src <= pwdata[CCSC_CFG_PLL_SRC_BIT];
      pll_cfg_r.mul <= pwdata[CCSC_CFG_PLL_MUL_LSB +: 4];
      pll_cfg_r.div <= pwdata[CCSC_CFG_PLL_DIV_LSB +: 2];
    end
  end

  // Requested system clock source
  always_ff @(posedge mclk) begin
    if (rst || wake) begin
      sw_r <= CCSC_SRC_MULTI;
    end else if (wr_acc && paddr == CCSC_OFF_CFG) begin
      sw_r <= ccsc_src_type'(pwdata[CCSC_CFG_SW_LSB +: 2]);
    end
  end

  // Switch sequencer: wait for target ready, then gate, then change over
  always_ff @(posedge mclk) begin
    if (rst || wake) begin
      state_r   <= CCSC_SW_IDLE;
      sws_r     <= CCSC_SRC_MULTI;
      tgt_r     <= CCSC_SRC_MULTI;
      gap_cnt_r <= '0;
    end else begin
      case (state_r)
        CCSC_SW_IDLE: begin
          if (sw_r != sws_r) begin
            state_r <= CCSC_SW_WAIT;
          end
        end
        CCSC_SW_WAIT: begin
          if (sw_r == sws_r) begin
            state_r <= CCSC_SW_IDLE;
          end else if (ready[ccsc_src_ix(sw_r)]) begin
            state_r   <= CCSC_SW_GAP;
            tgt_r     <= sw_r;
            gap_cnt_r <= CCSC_GAP_CYC - 3'h1;
          end
        end
        CCSC_SW_GAP: begin
          if (gap_cnt_r == '0) begin
            state_r <= CCSC_SW_IDLE;
            sws_r   <= tgt_r;
          end else begin
            gap_cnt_r <= gap_cnt_r - 3'h1;
          end
        end
        default: begin
          state_r <= CCSC_SW_IDLE;
        end
      endcase
    end
  end

  // Ready flags: a new ready edge wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_r <= '0;
      ie_r   <= '0;
    end else begin
      if (wr_acc && paddr == CCSC_OFF_INT) begin
        ie_r   <= pwdata[CCSC_INT_IE_LSB +: CCSC_NOSC];
        flag_r <= (flag_r & ~pwdata[CCSC_INT_CLR_LSB +: CCSC_NOSC]) | ready_rise;
      end else begin
        flag_r <= flag_r | ready_rise;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_irq <= 1'b0;
    end else begin
      clk_irq <= |(flag_r & ie_r);
    end
  end

  // Drive towards the oscillators and the system clock mux
  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_drive        <= '0;
      system_clock_sel <= CCSC_SRC_MULTI;
      system_clock_run <= 1'b0;
    end else begin
      osc_drive.enable                 <= en_eff;
      osc_drive.release_gate           <= ready;
      osc_drive.slow_ext_bypass        <= bypass_r & en_r[CCSC_IX_SLOW_EXT];
      osc_drive.fast_rc_factory_cal    <= frc_cal_r;
      osc_drive.fast_rc_trim           <= frc_trim_r;
      osc_drive.multispeed_range       <= range_r;
      osc_drive.multispeed_factory_cal <= ms_cal_r;
      osc_drive.multispeed_trim        <= ms_trim_r;
      system_clock_sel                 <= sws_r;
      system_clock_run                 <= (state_r != CCSC_SW_GAP) & ready[ccsc_src_ix(sws_r)];
    end
  end

  assign pll_cfg = pll_cfg_r;

  always_comb begin
    rd_mux = '0;
    case (paddr)
      CCSC_OFF_CTRL: begin
        rd_mux[CCSC_CTRL_EN_LSB +: CCSC_NOSC]  = en_r;
        rd_mux[CCSC_CTRL_RDY_LSB +: CCSC_NOSC] = ready;
        rd_mux[CCSC_CTRL_BYP_BIT]              = bypass_r;
      end
      CCSC_OFF_CAL: begin
        rd_mux[CCSC_CAL_FRC_CAL_LSB +: 8]  = frc_cal_r;
        rd_mux[CCSC_CAL_FRC_TRIM_LSB +: 5] = frc_trim_r;
        rd_mux[CCSC_CAL_RANGE_LSB +: 3]    = range_r;
        rd_mux[CCSC_CAL_MS_CAL_LSB +: 8]   = ms_cal_r;
        rd_mux[CCSC_CAL_MS_TRIM_LSB +: 8]  = ms_trim_r;
      end
      CCSC_OFF_CFG: begin
        rd_mux[CCSC_CFG_SW_LSB +: 2]      = sw_r;
        rd_mux[CCSC_CFG_SWS_LSB +: 2]     = sws_r;
        rd_mux[CCSC_CFG_PLL_SRC_BIT]      = pll_cfg_r.src;
        rd_mux[CCSC_CFG_PLL_MUL_LSB +: 4] = pll_cfg_r.mul;
        rd_mux[CCSC_CFG_PLL_DIV_LSB +: 2] = pll_cfg_r.div;
      end
      CCSC_OFF_INT: begin
        rd_mux[CCSC_INT_FLAG_LSB +: CCSC_NOSC] = flag_r;
        rd_mux[CCSC_INT_IE_LSB +: CCSC_NOSC]   = ie_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data captured in the setup phase, valid through the access phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_cal_reset_load: assert property ($past(rst) |-> frc_cal_r == $past(fast_rc_factory_cal))
    else $error("fast rc calibration not loaded at reset");
  a_trim_after_reset: assert property ($past(rst) |-> frc_trim_r == CCSC_FRC_TRIM_RST && range_r == CCSC_RANGE_RST)
    else $error("trim or range wrong after reset");
  a_gate_until_ready: assert property ((osc_drive.release_gate & ~$past(ready)) == '0)
    else $error("clock released before ready");
  a_wake_selects_ms: assert property (wake |=> sws_r == CCSC_SRC_MULTI && state_r == CCSC_SW_IDLE)
    else $error("wake-up did not select multispeed rc");
  a_standby_range: assert property (standby_wakeup |=> range_r == CCSC_RANGE_RST)
    else $error("standby wake-up did not restore range");
  a_stop_keeps_cal: assert property (stop_wakeup && !standby_wakeup && !wr_acc |=> $stable(ms_trim_r) && $stable(range_r))
    else $error("stop wake-up changed calibration");
  a_pll_cfg_frozen: assert property (en_r[CCSC_IX_PLL] |=> pll_cfg_r == $past(pll_cfg_r))
    else $error("pll configuration changed while enabled");
  a_pll_lock_irq: assert property (ready_rise[CCSC_IX_PLL] && ie_r[CCSC_IX_PLL] && !wr_acc |=> ##1 clk_irq)
    else $error("pll lock interrupt missing");
  a_bypass_needs_en: assert property (osc_drive.slow_ext_bypass |-> $past(en_r[CCSC_IX_SLOW_EXT]))
    else $error("bypass without enable");
  a_watchdog_forces: assert property (wd_sync2_r |=> osc_drive.enable[CCSC_IX_SLOW_INT])
    else $error("watchdog did not keep slow rc running");
  a_live_src_kept: assert property (!wake |=> ($past(in_use) & ~en_r) == '0)
    else $error("live clock source was stopped");
  a_switch_deferred: assert property (state_r == CCSC_SW_WAIT && !ready[ccsc_src_ix(sw_r)] |=> $stable(sws_r))
    else $error("switch to unready source");
  a_gap_length: assert property ($rose(state_r == CCSC_SW_GAP) |-> (state_r == CCSC_SW_GAP) [*4] ##1 sws_r == $past(tgt_r))
    else $error("changeover gap has wrong length");

  c_switch_to_pll: cover property (state_r == CCSC_SW_GAP ##1 sws_r == CCSC_SRC_PLL);
  c_deferred_switch: cover property (state_r == CCSC_SW_WAIT [*3] ##1 state_r == CCSC_SW_GAP);
  c_pll_irq: cover property (ready_rise[CCSC_IX_PLL] ##2 clk_irq);

endmodule : ccsc_top
`default_nettype wire

// >>> verif/ccsc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccsc_osc_model #(
  parameter int DLY = 12
) (
  input  wire logic       mclk,
  input  wire logic [5:0] enable,
  input  wire logic       bypass,
  output logic [5:0]      osc_stable
);
  int cnt [6];

  // Each source settles DLY cycles after enable and stops at once when disabled
  always @(posedge mclk) begin
    for (int i = 0; i < 6; i++) begin
      if (!enable[i]) cnt[i] <= 0;
      else if (cnt[i] < DLY) cnt[i] <= cnt[i] + 1;
    end
  end

  // A bypass clock is present as soon as it is selected
  always_comb begin
    for (int i = 0; i < 6; i++) osc_stable[i] = enable[i] && cnt[i] >= DLY;
    if (bypass && enable[1]) osc_stable[1] = 1'b1;
  end
endmodule : ccsc_osc_model
`default_nettype wire

// >>> verif/clock_source_system_clock_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clock_source_system_clock_control_tb;
  import ccsc_pkg::*;
  logic               mclk = 0;
  logic               rst = 1;
  logic               psel = 0;
  logic               penable = 0;
  logic               pwrite = 0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [7:0]         fcal = 8'ha5;
  logic [7:0]         mcal = 8'h3c;
  logic               wdog = 0;
  logic               stop_wk = 0;
  logic               stby_wk = 0;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               pready;
  logic               pslverr;
  logic               err;
  logic               run;
  logic               irq;
  logic [5:0]         stable;
  ccsc_osc_drive_type drv;
  ccsc_pll_cfg_type   pcfg;
  ccsc_src_type       sel;
  int                 failures = 0;
  int                 checked = 0;

  always #2.5 mclk = ~mclk;

  ccsc_top dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_rc_factory_cal(fcal), .multispeed_factory_cal(mcal), .osc_stable(stable),
    .watchdog_active(wdog), .stop_wakeup(stop_wk), .standby_wakeup(stby_wk),
    .osc_drive(drv), .pll_cfg(pcfg), .system_clock_sel(sel), .system_clock_run(run),
    .clk_irq(irq));

  ccsc_osc_model model (.mclk(mclk), .enable(drv.enable), .bypass(drv.slow_ext_bypass),
    .osc_stable(stable));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chb

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge mclk);
  endtask : apb

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while ((rd & m) !== v && n < 100) begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    chk(rd & m, v);
  endtask : poll

  function automatic logic [31:0] cfg(logic [1:0] sw, logic s, logic [3:0] m, logic [1:0] dv);
    return {14'h0, dv, 2'h0, m, 1'b0, s, 6'h0, sw};
  endfunction : cfg

  task automatic final_report;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    failures++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, CCSC_OFF_CAL, 32'h0);
    chk(rd, {CCSC_MS_TRIM_RST, mcal, CCSC_RANGE_RST, CCSC_FRC_TRIM_RST, fcal});
    chk({16'h0, drv.fast_rc_factory_cal, drv.multispeed_factory_cal}, {16'h0, fcal, mcal});
    apb(1'b0, CCSC_OFF_CTRL, 32'h0);
    chk(rd & 32'h1003f, {26'h0, CCSC_EN_RST});
    poll(CCSC_OFF_CTRL, 32'h800, 32'h800);
    apb(1'b0, CCSC_OFF_CFG, 32'h0);
    chk(rd, cfg(2'h0, 1'b0, CCSC_PLL_MUL_RST, CCSC_PLL_DIV_RST));
    // Lock interrupt enabled; multiplier code kept within the voltage range limits
    apb(1'b1, CCSC_OFF_INT, 32'h2000);
    apb(1'b1, CCSC_OFF_CFG, cfg(2'h0, 1'b1, 4'h3, 2'h2));
    chk({25'h0, pcfg}, {25'h0, 1'b1, 4'h3, 2'h2});
    apb(1'b1, CCSC_OFF_CTRL, 32'h1c);
    chb(drv.release_gate[CCSC_IX_FAST_RC], 1'b0);
    poll(CCSC_OFF_CTRL, 32'h400, 32'h400);
    chb(drv.release_gate[CCSC_IX_FAST_RC], 1'b1);
    poll(CCSC_OFF_CTRL, 32'h1000, 32'h1000);
    // Switch to the fast RC; the system clock is gated during changeover
    apb(1'b1, CCSC_OFF_CFG, cfg(2'h1, 1'b1, 4'h3, 2'h2));
    repeat (4) @(posedge mclk);
    chb(run, 1'b0);
    poll(CCSC_OFF_CFG, 32'h30, 32'h10);
    repeat (2) @(posedge mclk);
    chb(sel === CCSC_SRC_FAST_RC && run === 1'b1, 1'b1);
    apb(1'b1, CCSC_OFF_CTRL, 32'h18);
    apb(1'b0, CCSC_OFF_CTRL, 32'h0);
    chk(rd & 32'h3f, 32'h1c);
    // Multiplier lock raises the interrupt, cleared by write one
    apb(1'b1, CCSC_OFF_CTRL, 32'h3c);
    poll(CCSC_OFF_CTRL, 32'h2000, 32'h2000);
    repeat (2) @(posedge mclk);
    chb(irq, 1'b1);
    apb(1'b0, CCSC_OFF_INT, 32'h0);
    chb(rd[CCSC_INT_FLAG_LSB + CCSC_IX_PLL], 1'b1);
    apb(1'b1, CCSC_OFF_INT, 32'h202000);
    repeat (2) @(posedge mclk);
    chb(irq, 1'b0);
    apb(1'b1, CCSC_OFF_CFG, cfg(2'h3, 1'b0, 4'h5, 2'h3));
    chk({25'h0, pcfg}, {25'h0, 1'b1, 4'h3, 2'h2});
    poll(CCSC_OFF_CFG, 32'h30, 32'h30);
    apb(1'b1, CCSC_OFF_CTRL, 32'h0c);
    apb(1'b0, CCSC_OFF_CTRL, 32'h0);
    chk(rd & 32'h3f, 32'h3c);
    // Reconfigure: leave the multiplier, stop it, wait for unlock, reprogram
    apb(1'b1, CCSC_OFF_CFG, cfg(2'h0, 1'b1, 4'h3, 2'h2));
    poll(CCSC_OFF_CFG, 32'h30, 32'h0);
    apb(1'b1, CCSC_OFF_CTRL, 32'h0c);
    poll(CCSC_OFF_CTRL, 32'h2000, 32'h0);
    apb(1'b1, CCSC_OFF_CFG, cfg(2'h0, 1'b0, 4'h5, 2'h3));
    chk({25'h0, pcfg}, {25'h0, 1'b0, 4'h5, 2'h3});
    // Switch to a source that is off waits until it is ready
    apb(1'b1, CCSC_OFF_CFG, cfg(2'h2, 1'b0, 4'h5, 2'h3));
    repeat (30) @(posedge mclk);
    apb(1'b0, CCSC_OFF_CFG, 32'h0);
    chk(rd & 32'h30, 32'h0);
    apb(1'b1, CCSC_OFF_CTRL, 32'h1c);
    poll(CCSC_OFF_CFG, 32'h30, 32'h20);
    apb(1'b1, CCSC_OFF_CTRL, 32'h1001e);
    repeat (2) @(posedge mclk);
    chb(drv.slow_ext_bypass & drv.enable[CCSC_IX_SLOW_EXT], 1'b1);
    poll(CCSC_OFF_CTRL, 32'h200, 32'h200);
    apb(1'b0, CCSC_OFF_INT, 32'h0);
    chb(rd[CCSC_INT_FLAG_LSB + CCSC_IX_SLOW_EXT], 1'b1);
    chb(irq, 1'b0);
    @(posedge mclk);
    wdog <= 1'b1;
    repeat (5) @(posedge mclk);
    chb(drv.enable[CCSC_IX_SLOW_INT], 1'b1);
    poll(CCSC_OFF_CTRL, 32'h100, 32'h100);
    // Trim and range writes, with the unused range code refused
    apb(1'b1, CCSC_OFF_CAL, {8'h33, 8'h00, 3'h0, 5'h14, 8'h00});
    repeat (2) @(posedge mclk);
    chk({16'h0, drv.multispeed_trim, drv.multispeed_range, drv.fast_rc_trim}, {16'h0, 8'h33, 3'h0, 5'h14});
    apb(1'b1, CCSC_OFF_CAL, {8'h33, 8'h00, 3'h7, 5'h14, 8'h00});
    apb(1'b0, CCSC_OFF_CAL, 32'h0);
    chk(rd, {8'h33, mcal, 3'h0, 5'h14, fcal});
    @(posedge mclk);
    stop_wk <= 1'b1;
    @(posedge mclk);
    stop_wk <= 1'b0;
    poll(CCSC_OFF_CFG, 32'h30, 32'h0);
    chb(sel === CCSC_SRC_MULTI, 1'b1);
    apb(1'b0, CCSC_OFF_CAL, 32'h0);
    chk(rd, {8'h33, mcal, 3'h0, 5'h14, fcal});
    @(posedge mclk);
    stby_wk <= 1'b1;
    @(posedge mclk);
    stby_wk <= 1'b0;
    apb(1'b0, CCSC_OFF_CAL, 32'h0);
    chk(rd, {CCSC_MS_TRIM_RST, mcal, CCSC_RANGE_RST, CCSC_FRC_TRIM_RST, fcal});
    // Unmapped address is refused with an error
    apb(1'b1, 8'h10, 32'hffffffff);
    chb(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    // Second reset reloads new factory values
    @(posedge mclk);
    fcal <= 8'h5a;
    mcal <= 8'hc3;
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, CCSC_OFF_CAL, 32'h0);
    chk(rd, {CCSC_MS_TRIM_RST, 8'hc3, CCSC_RANGE_RST, CCSC_FRC_TRIM_RST, 8'h5a});
    final_report();
  end
endmodule : clock_source_system_clock_control_tb
`default_nettype wire
